// ### hdl/ccs_core_state.sv
// condition flags, summary overflow, tick counter and machine state word
`timescale 1ns/1ps
module ccs_core_state #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // compare and record requests
  input  wire logic [2:0]   updKind,
  input  wire logic [2:0]   updField,
  input  wire logic [W-1:0] cmpOpA,
  input  wire logic [W-1:0] cmpOpB,
  input  wire logic [15:0]  immediateField,
  input  wire logic         useImmediate,
  input  wire logic         immSigned,
  input  wire logic [W-1:0] recordResult,
  input  wire logic         ovfFormValid,
  input  wire logic         ovfOccurred,
  // special flag-register writes
  input  wire logic         flagsWrite,
  input  wire logic [7:0]   flagsMask,
  input  wire logic [W-1:0] flagsWriteData,
  input  wire logic         ovfToFieldMove,
  // exception register write
  input  wire logic         xerWrite,
  input  wire logic [W-1:0] xerWriteData,
  // tick counter
  input  wire logic         tickWriteLow,
  input  wire logic         tickWriteHigh,
  input  wire logic [W-1:0] tickWriteData,
  // state word access
  input  wire logic         stateWrite,
  input  wire logic [W-1:0] stateWriteData,
  input  wire logic         extEnableWrite,
  input  wire logic         extEnableValue,
  // interrupt entry and return
  input  wire logic         irqEntry,
  input  wire logic [W-1:0] irqEntryState,
  input  wire logic         irqReturn,
  input  wire logic [W-1:0] irqSavedState,
  input  wire logic         debugClearWait,
  // interrupt sources to gate
  input  wire logic         critIrqIn,
  input  wire logic         watchdogFirstIn,
  input  wire logic         extIrqIn,
  input  wire logic         programmableIntervalTimerIn,
  input  wire logic         fixedIntervalTimerIn,
  input  wire logic         machineCheckIn,
  input  wire logic         debugIrqIn,
  // register read values
  output logic [W-1:0]      conditionFlagsReg,
  output logic [W-1:0]      fixedPointExceptionReg,
  output logic [W-1:0]      tickCountLow,
  output logic [W-1:0]      tickCountHigh,
  output logic [W-1:0]      machineStateControl,
  output logic [W-1:0]      savedStateOut,
  // decoded state
  output logic              waitState,
  output logic              critIrqGated,
  output logic              watchdogFirstGated,
  output logic              extIrqGated,
  output logic              pitGated,
  output logic              fitGated,
  output logic              machineCheckGated,
  output logic              debugIrqGated,
  output logic              debugWaitEnabled,
  output logic              supervisorState,
  output logic              instrTranslateEn,
  output logic              dataTranslateEn
);
  localparam int unsigned TOP = ccs_pkg::BE_TOP;

  logic [W-1:0]  flags_reg;
  logic [W-1:0]  flags_next;
  logic [W-1:0]  xer_reg;
  logic [W-1:0]  xer_next;
  logic [63:0]   tick_reg;
  logic [63:0]   tick_next;
  logic [W-1:0]  state_reg;
  logic [W-1:0]  state_next;
  logic [W-1:0]  saved_reg;
  logic [W-1:0]  saved_next;

  logic [W-1:0]  secondOp;
  logic [3:0]    cmpField;
  logic [3:0]    recField;
  logic          sumOvfNow;
  logic          isSignedCmp;
  ccs_pkg::ccs_upd_t kind;

  assign kind = ccs_pkg::ccs_upd_t'(updKind);
  assign isSignedCmp = (kind == ccs_pkg::CCS_UPD_CMP_SIGNED);

  // immediate sign- or zero-extended as immSigned selects, whatever the compare type
  always_comb begin
    if (useImmediate) begin
      secondOp = immSigned ? {{(W-16){immediateField[15]}}, immediateField}
                           : {{(W-16){1'b0}}, immediateField}; // [RULE_03]
    end else begin
      secondOp = cmpOpB; // [RULE_03]
    end
  end

  // summary overflow as it stands at completion, including this op's overflow
  assign sumOvfNow = xer_reg[TOP - ccs_pkg::XR_SUM_OVF] | (ovfFormValid & ovfOccurred); // [RULE_06]

  ccs_field_cmp #(
    .W (W)
  ) u_cmp (
    .opA       (cmpOpA),
    .opB       (secondOp),
    .signedCmp (isSignedCmp),
    .sumOvf    (sumOvfNow),
    .field     (cmpField)
  );

  // record form: signed compare to zero on the truncated result
  ccs_field_cmp #(
    .W (W)
  ) u_rec (
    .opA       (recordResult), // [RULE_07] [RULE_08]
    .opB       ({W{1'b0}}),
    .signedCmp (1'b1),
    .sumOvf    (sumOvfNow),
    .field     (recField) // [RULE_05]
  );

  // flags register next value; field 0 at the top four bits
  always_comb begin
    flags_next = flags_reg;
    case (kind)
      ccs_pkg::CCS_UPD_CMP_SIGNED,
      ccs_pkg::CCS_UPD_CMP_UNSIGNED: begin
        flags_next[TOP - 4*updField -: 4] = cmpField; // [RULE_03] [RULE_21] [RULE_23]
      end
      ccs_pkg::CCS_UPD_RECORD: begin
        flags_next[TOP -: 4] = recField; // [RULE_05] [RULE_21]
      end
      ccs_pkg::CCS_UPD_SPECIAL: begin
        flags_next = flags_reg; // handled by the special paths below [RULE_09]
      end
      ccs_pkg::CCS_UPD_NONE: begin
        flags_next = flags_reg;
      end
      default: begin
        flags_next = flags_reg;
      end
    endcase
    // masked whole-field move
    if (flagsWrite) begin
      for (int i = 0; i < 8; i++) begin
        if (flagsMask[7-i]) begin
          flags_next[TOP - 4*i -: 4] = flagsWriteData[TOP - 4*i -: 4]; // [RULE_09]
        end
      end
    end
    // overflow bits copied into selected field
    if (ovfToFieldMove) begin
      flags_next[TOP - 4*updField -: 4] = xer_reg[TOP -: 4]; // [RULE_09]
    end
  end

  // exception register: overflow sets, writes load, the move clears
  always_comb begin
    xer_next = xer_reg;
    if (ovfFormValid) begin
      xer_next[TOP - ccs_pkg::XR_OVF] = ovfOccurred;
    end
    if (xerWrite) begin
      xer_next = xerWriteData; // [RULE_22]
    end else if (ovfToFieldMove) begin
      xer_next[TOP -: 4] = 4'h0; // [RULE_22]
    end
    // a simultaneous overflow keeps summary overflow set despite the clearing move
    if (ovfFormValid && ovfOccurred && !xerWrite) begin
      xer_next[TOP - ccs_pkg::XR_SUM_OVF] = 1'b1; // [RULE_22]
    end
  end

  // free-running tick; halves load only through their own ports
  always_comb begin
    tick_next = tick_reg + 64'h1; // [RULE_10]
    if (tickWriteLow) begin
      tick_next[31:0] = tickWriteData; // [RULE_12]
    end
    if (tickWriteHigh) begin
      tick_next[63:32] = tickWriteData; // [RULE_12]
    end
  end

  // state word: interrupt entry beats return beats software writes
  always_comb begin
    state_next = state_reg;
    saved_next = saved_reg;
    if (irqEntry) begin
      saved_next = state_reg; // [RULE_14]
      state_next = irqEntryState & ccs_pkg::MS_WMASK; // [RULE_14] [RULE_15]
    end else if (irqReturn) begin
      state_next = irqSavedState & ccs_pkg::MS_WMASK; // [RULE_14]
    end else if (stateWrite) begin
      state_next = stateWriteData & ccs_pkg::MS_WMASK; // [RULE_13] [RULE_24]
    end else if (extEnableWrite) begin
      state_next[TOP - ccs_pkg::MS_EXT] = extEnableValue; // [RULE_13]
    end
    // taking an interrupt or a debug clear ends the wait state
    if (irqEntry || debugClearWait) begin
      state_next[TOP - ccs_pkg::MS_WAIT] = 1'b0; // [RULE_15]
    end
  end

  // register stage; reset also ends any wait
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= ccs_pkg::FLAGS_RESET;
      xer_reg   <= ccs_pkg::XR_RESET;
      tick_reg  <= ccs_pkg::TICK_RESET;
      state_reg <= ccs_pkg::MS_RESET; // [RULE_15]
      saved_reg <= ccs_pkg::MS_RESET;
    end else begin
      flags_reg <= flags_next;
      xer_reg   <= xer_next;
      tick_reg  <= tick_next;
      state_reg <= state_next;
      saved_reg <= saved_next;
    end
  end

  // read values; tick halves need no privilege check
  assign conditionFlagsReg      = flags_reg;
  assign fixedPointExceptionReg = xer_reg;
  assign tickCountLow           = tick_reg[31:0];  // [RULE_11]
  assign tickCountHigh          = tick_reg[63:32]; // [RULE_11]
  assign machineStateControl    = state_reg & ccs_pkg::MS_WMASK; // [RULE_24]
  assign savedStateOut          = saved_reg;

  // state bit decode and interrupt gating
  assign waitState          = state_reg[TOP - ccs_pkg::MS_WAIT]; // [RULE_15]
  assign critIrqGated       = critIrqIn & state_reg[TOP - ccs_pkg::MS_CRIT]; // [RULE_16]
  assign watchdogFirstGated = watchdogFirstIn & state_reg[TOP - ccs_pkg::MS_CRIT]; // [RULE_16]
  assign extIrqGated        = extIrqIn & state_reg[TOP - ccs_pkg::MS_EXT]; // [RULE_17]
  assign pitGated           = programmableIntervalTimerIn
                              & state_reg[TOP - ccs_pkg::MS_EXT]; // [RULE_17]
  assign fitGated           = fixedIntervalTimerIn
                              & state_reg[TOP - ccs_pkg::MS_EXT]; // [RULE_17]
  assign supervisorState    = !state_reg[TOP - ccs_pkg::MS_PROBLEM]; // [RULE_18]
  assign machineCheckGated  = machineCheckIn & state_reg[TOP - ccs_pkg::MS_MCHK]; // [RULE_19]
  assign debugWaitEnabled   = state_reg[TOP - ccs_pkg::MS_DWAIT]; // [RULE_19]
  assign debugIrqGated      = debugIrqIn & state_reg[TOP - ccs_pkg::MS_DEBUG]; // [RULE_19]
  assign instrTranslateEn   = state_reg[TOP - ccs_pkg::MS_ITRANS]; // [RULE_20]
  assign dataTranslateEn    = state_reg[TOP - ccs_pkg::MS_DTRANS]; // [RULE_20]
endmodule

// ### hdl/ccs_field_cmp.sv
// signed or unsigned compare producing one 4-bit flag field
`timescale 1ns/1ps
module ccs_field_cmp #(
  parameter int unsigned W = 32
) (
  // operands
  input  wire logic [W-1:0] opA,
  input  wire logic [W-1:0] opB,
  input  wire logic         signedCmp,
  input  wire logic         sumOvf,
  // field, big-endian: [3] less, [2] greater, [1] equal, [0] overflow copy
  output logic      [3:0]   field
);
  logic isLess;
  logic isEqual;

  // signed view uses top bit as sign; unsigned uses all bits as magnitude
  always_comb begin
    isEqual = (opA == opB);
    if (signedCmp) begin
      isLess = ($signed(opA) < $signed(opB)); // [RULE_01]
    end else begin
      isLess = (opA < opB); // [RULE_02]
    end
    field = {isLess, !isLess && !isEqual, isEqual, sumOvf}; // [RULE_04]
  end
endmodule

// ### pkg/ccs_pkg.sv
// constants and types for the core condition and state register block
//
// Behaviour
// RULE_01 - arithmetic compare treats both 32-bit operands as signed twos-complement.
// RULE_02 - logical compare treats both operands as unsigned 32-bit magnitudes.
// RULE_03 - compare writes selected field; second operand is register or immediate.
// RULE_04 - compare field: less bit 0, greater bit 1, equal bit 2, overflow copy bit 3.
// RULE_05 - record form sets field 0: negative, positive nonzero, or zero result.
// RULE_06 - field 0 overflow bit copies summary overflow as it stands at completion.
// RULE_07 - record forms compare 32-bit result to zero signed, even for bitwise logic.
// RULE_08 - on overflow, flags reflect the truncated 32-bit result, overflow bit set.
// RULE_09 - compares, flag logic, field copy, mask move, conditional store skip generic rule.
// RULE_10 - 64-bit tick counter seen as low and high 32-bit halves.
// RULE_11 - tick halves readable in user mode, read-only, no privileged read path.
// RULE_12 - tick counter loaded only through separate low and high write ports.
// RULE_13 - state word written and read whole; external enable also set or cleared alone.
// RULE_14 - interrupt entry saves and alters state word; return restores it.
// RULE_15 - wait bit 13 holds wait state until interrupt, reset or debug clear.
// RULE_16 - bit 14 gates critical input and first watchdog time-out.
// RULE_17 - bit 16 gates external input, interval timer and fixed timer interrupts.
// RULE_18 - bit 17 zero is supervisor state, one is user state.
// RULE_19 - bit 19 machine check, bit 21 debug wait, bit 22 debug interrupts enable.
// RULE_20 - bit 26 enables instruction translation, bit 27 data translation.
// RULE_21 - flags register is eight 4-bit fields, field 0 in bits 0 to 3.
// RULE_22 - summary overflow is exception bit 0; set by overflow or write, cleared too.
// RULE_23 - bit 0 is the most significant bit of each 32-bit register.
// RULE_24 - reserved state bits read zero and ignore writes.
package ccs_pkg;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned FIELD_W  = 4;
  localparam int unsigned NFIELDS  = 8;
  localparam int unsigned FSEL_W   = 3;

  // big-endian bit index to little-endian vector index
  localparam int unsigned BE_TOP = WORD_W - 1;

  // positions inside a 4-bit field, big-endian numbering
  localparam int unsigned FLD_LESS    = 0;
  localparam int unsigned FLD_GREATER = 1;
  localparam int unsigned FLD_EQUAL   = 2;
  localparam int unsigned FLD_OVF     = 3;

  // exception register bit positions (big-endian)
  localparam int unsigned XR_SUM_OVF = 0;
  localparam int unsigned XR_OVF     = 1;

  // state word bit positions (big-endian)
  localparam int unsigned MS_WAIT    = 13;
  localparam int unsigned MS_CRIT    = 14;
  localparam int unsigned MS_EXT     = 16;
  localparam int unsigned MS_PROBLEM = 17;
  localparam int unsigned MS_MCHK    = 19;
  localparam int unsigned MS_DWAIT   = 21;
  localparam int unsigned MS_DEBUG   = 22;
  localparam int unsigned MS_ITRANS  = 26;
  localparam int unsigned MS_DTRANS  = 27;

  // writable mask in little-endian index form; reserved bits read zero
  localparam logic [31:0] MS_WMASK =
    (32'h1 << (BE_TOP - MS_WAIT))    | (32'h1 << (BE_TOP - MS_CRIT))  |
    (32'h1 << (BE_TOP - MS_EXT))     | (32'h1 << (BE_TOP - MS_PROBLEM)) |
    (32'h1 << (BE_TOP - MS_MCHK))    | (32'h1 << (BE_TOP - MS_DWAIT)) |
    (32'h1 << (BE_TOP - MS_DEBUG))   | (32'h1 << (BE_TOP - MS_ITRANS)) |
    (32'h1 << (BE_TOP - MS_DTRANS));

  localparam logic [31:0] MS_RESET   = 32'h0;
  localparam logic [31:0] FLAGS_RESET = 32'h0;
  localparam logic [31:0] XR_RESET   = 32'h0;
  localparam logic [63:0] TICK_RESET = 64'h0;

  // generic flag-update kinds from the execution unit
  typedef enum logic [2:0] {
    CCS_UPD_NONE,
    CCS_UPD_CMP_SIGNED,
    CCS_UPD_CMP_UNSIGNED,
    CCS_UPD_RECORD,
    CCS_UPD_SPECIAL
  } ccs_upd_t;
endpackage

// ### verif/ccs_irq_source.sv
// interrupt source levels from the execution side, pseudo-random pattern
`timescale 1ns/1ps
module ccs_irq_source (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // crit, watchdog, ext, interval, fixed, machine check, debug
  output logic      [6:0] irqLines
);
  // falling edge moves, so gated outputs settle before the bench samples
  always @(negedge clk) begin
    irqLines <= srst ? 7'h5b : {irqLines[5:0], irqLines[6] ^ irqLines[5]};
  end
endmodule

// ### verif/ccs_properties.sv
// concurrent checks on the condition, tick and state register block
`timescale 1ns/1ps
module ccs_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // requests
  input wire logic [2:0]  updKind,
  input wire logic [2:0]  updField,
  input wire logic [31:0] cmpOpA,
  input wire logic [31:0] cmpOpB,
  input wire logic        useImmediate,
  input wire logic [31:0] recordResult,
  input wire logic        ovfFormValid,
  input wire logic        ovfOccurred,
  input wire logic        flagsWrite,
  input wire logic        ovfToFieldMove,
  input wire logic        xerWrite,
  input wire logic        tickWriteLow,
  input wire logic        tickWriteHigh,
  input wire logic        stateWrite,
  input wire logic [31:0] stateWriteData,
  input wire logic        extEnableWrite,
  input wire logic        extEnableValue,
  input wire logic        irqEntry,
  input wire logic        irqReturn,
  input wire logic        debugClearWait,
  input wire logic        critIrqIn,
  // observed state
  input wire logic [31:0] conditionFlagsReg,
  input wire logic [31:0] fixedPointExceptionReg,
  input wire logic [31:0] tickCountLow,
  input wire logic [31:0] tickCountHigh,
  input wire logic [31:0] machineStateControl,
  input wire logic        waitState,
  input wire logic        critIrqGated
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // signed outcome of the register operands, kept apart from the design
  wire sLess = $signed(cmpOpA) < $signed(cmpOpB);
  wire sMore = $signed(cmpOpA) > $signed(cmpOpB);
  property p_cmp; updKind == 3'd1 && !useImmediate && !flagsWrite && !ovfToFieldMove
    |=> conditionFlagsReg[31 - 4*$past(updField) -: 3] == $past({sLess, sMore, cmpOpA == cmpOpB});
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare field wrong");
  property p_rec; updKind == 3'd3 && !flagsWrite && !ovfToFieldMove
    |=> conditionFlagsReg[31:28] == {$past(recordResult[31]),
    $past(recordResult != 0 && !recordResult[31]), $past(recordResult == 0),
    fixedPointExceptionReg[31]};
  endproperty
  a_rec: assert property (p_rec) else $error("record field wrong");
  property p_so; ovfFormValid && ovfOccurred && !xerWrite
    |=> fixedPointExceptionReg[31];
  endproperty
  a_so: assert property (p_so) else $error("summary overflow not set");
  property p_tick; !tickWriteLow && !tickWriteHigh
    |=> {tickCountHigh, tickCountLow} == $past({tickCountHigh, tickCountLow}) + 64'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("tick count step wrong");
  property p_ee; extEnableWrite && !stateWrite && !irqEntry && !irqReturn
    |=> machineStateControl[15] == $past(extEnableValue);
  endproperty
  a_ee: assert property (p_ee) else $error("external enable write lost");
  property p_wait; debugClearWait && !stateWrite && !irqReturn |=> !waitState; endproperty
  a_wait: assert property (p_wait) else $error("wait not cleared");
  property p_crit; critIrqGated == (critIrqIn && machineStateControl[17]); endproperty
  a_crit: assert property (p_crit) else $error("critical gating wrong");
  // a whole-word write lands with every reserved bit dropped
  property p_rsv; stateWrite && !irqEntry && !irqReturn && !debugClearWait
    |=> machineStateControl == ($past(stateWriteData) & ccs_pkg::MS_WMASK);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved state bit set");
  // main scenarios reached
  c_cmp: cover property (updKind == 3'd1 && !useImmediate);
  c_irq: cover property (irqEntry ##1 irqReturn);
  c_load: cover property (tickWriteLow && tickWriteHigh);
endmodule

// ### verif/tb_top.sv
// self-checking bench for the condition, tick and state register block
`timescale 1ns/1ps
module tb_top;
  // stimulus
  logic        clk, srst, useImmediate, immSigned, ovfFormValid, ovfOccurred, flagsWrite;
  logic        ovfToFieldMove, xerWrite, tickWriteLow, tickWriteHigh, stateWrite, so;
  logic        extEnableWrite, extEnableValue, irqEntry, irqReturn, debugClearWait;
  logic [2:0]  updKind, updField;
  logic [3:0]  e;
  logic [7:0]  flagsMask;
  logic [15:0] immediateField;
  logic [31:0] cmpOpA, cmpOpB, recordResult, flagsWriteData, xerWriteData, tickWriteData;
  logic [31:0] stateWriteData, irqEntryState, irqSavedState, m, b;
  // observed
  logic [31:0] conditionFlagsReg, fixedPointExceptionReg, tickCountLow, tickCountHigh;
  logic [31:0] machineStateControl, savedStateOut;
  logic        waitState, critIrqGated, watchdogFirstGated, extIrqGated, pitGated, fitGated;
  logic        machineCheckGated, debugIrqGated, debugWaitEnabled, supervisorState;
  logic        instrTranslateEn, dataTranslateEn;
  wire  [6:0]  irq;
  wire         critIrqIn, watchdogFirstIn, extIrqIn, programmableIntervalTimerIn;
  wire         fixedIntervalTimerIn, machineCheckIn, debugIrqIn;
  wire  [6:0]  gated = {critIrqGated, watchdogFirstGated, extIrqGated, pitGated, fitGated,
    machineCheckGated, debugIrqGated};
  wire  [4:0]  modes = {supervisorState, debugWaitEnabled, instrTranslateEn, dataTranslateEn,
    waitState};
  int          failures = 0;
  int          cmp_count = 0;
  assign {critIrqIn, watchdogFirstIn, extIrqIn, programmableIntervalTimerIn} = irq[6:3];
  assign {fixedIntervalTimerIn, machineCheckIn, debugIrqIn} = irq[2:0];
  ccs_core_state #(.W(32)) dut (.*);
  ccs_irq_source partner (.clk(clk), .srst(srst), .irqLines(irq));
  always #20 clk = ~clk;
  // pulses last exactly one edge
  task automatic go;
    @(posedge clk);
    #1;
    {ovfFormValid, flagsWrite, ovfToFieldMove, xerWrite, tickWriteLow, tickWriteHigh} = '0;
    {stateWrite, extEnableWrite, irqEntry, irqReturn, debugClearWait, updKind} = '0;
  endtask
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected flag fields, from the compare and zero-test rules
  function automatic logic [3:0] exp_cmp(logic sgn, logic [31:0] a, logic [31:0] r, logic ov);
    logic lt;
    lt = sgn ? $signed(a) < $signed(r) : a < r;
    return {lt, !lt && a != r, a == r, ov};
  endfunction
  function automatic logic [3:0] exp_rec(logic [31:0] r, logic ov);
    return {r[31], !r[31] && r != 32'h0, r == 32'h0, ov};
  endfunction
  task automatic end_of_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: the sequence needs under two hundred cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(9246));
    {clk, srst} = 2'b01;
    go();
    {useImmediate, immSigned, ovfOccurred, extEnableValue, updField, flagsMask} = '0;
    {immediateField, cmpOpA, cmpOpB, recordResult, flagsWriteData, xerWriteData} = '0;
    {tickWriteData, stateWriteData, irqEntryState, irqSavedState} = '0;
    repeat (7) @(posedge clk);
    #1;
    srst = 0;
    chk("rst", {machineStateControl, modes}, 37'h10);
    // compares with corners, then record forms with overflow
    for (int i = 0; i < 40; i++) begin
      so = 1'($urandom);
      xerWriteData = {so, 31'h0};
      xerWrite = 1;
      go();
      chk("so", fixedPointExceptionReg[31], so);
      cmpOpA = i < 2 ? 32'h0 : $urandom;
      cmpOpB = i < 2 ? 32'hffffffff : i == 2 ? cmpOpA : $urandom;
      immediateField = 16'($urandom);
      {useImmediate, immSigned} = i < 3 ? 2'b0 : 2'($urandom);
      updKind = 3'(1 + i % 2);
      updField = 3'($urandom);
      b = useImmediate ? (immSigned ? {{16{immediateField[15]}}, immediateField}
        : {16'h0, immediateField}) : cmpOpB;
      e = exp_cmp(updKind == 3'd1, cmpOpA, b, so);
      go();
      chk("cmp", conditionFlagsReg[31 - 4*updField -: 4], e);
      recordResult = i == 0 ? 32'h0 : i == 1 ? 32'h80000000 : $urandom;
      {ovfFormValid, ovfOccurred, updKind} = {1'b1, 1'($urandom), 3'd3};
      so = so | ovfOccurred;
      e = exp_rec(recordResult, so);
      go();
      chk("rec", conditionFlagsReg[31:28], e);
    end
    {updKind, flagsWrite, flagsMask, flagsWriteData} = {3'd3, 1'b1, 8'h80, 32'ha0000000};
    go();
    chk("fmove", conditionFlagsReg[31:28], 4'ha);
    // special kind must leave field 0 alone even with a zero result standing
    {updKind, recordResult} = {3'd4, 32'h0};
    go();
    chk("special", conditionFlagsReg[31:28], 4'ha);
    {xerWrite, xerWriteData} = {1'b1, 32'he0000000};
    go();
    {ovfToFieldMove, updField} = {1'b1, 3'd5};
    go();
    chk("xmove", {conditionFlagsReg[11:8], fixedPointExceptionReg[31:28]}, 8'he0);
    {tickWriteLow, tickWriteHigh, tickWriteData} = {2'b11, 32'hfffffffe};
    go();
    chk("tload", {tickCountHigh, tickCountLow}, 64'hfffffffe_fffffffe);
    repeat (2) go();
    chk("tcarry", {tickCountHigh, tickCountLow}, 64'hffffffff_00000000);
    // whole-word writes, single-bit enable writes and the decoded outputs
    for (int i = 0; i < 16; i++) begin
      stateWriteData = i == 0 ? 32'hffffffff : $urandom;
      m = stateWriteData & ccs_pkg::MS_WMASK;
      stateWrite = 1;
      go();
      chk("state", machineStateControl, m);
      chk("gate", gated, irq & {{2{m[17]}}, {3{m[15]}}, m[12], m[9]});
      chk("mode", modes, {!m[14], m[10], m[5], m[4], m[18]});
      {extEnableWrite, extEnableValue} = {1'b1, !m[15]};
      go();
      m[15] = !m[15];
      chk("ee", machineStateControl, m);
    end
    {irqEntry, irqEntryState} = {1'b1, $urandom & 32'hfffbffff};
    go();
    b = irqEntryState & ccs_pkg::MS_WMASK;
    chk("entry", {savedStateOut, machineStateControl}, {m, b});
    // restored word carries the wait bit, so the return re-enters wait
    m = m | 32'h00040000;
    {irqReturn, irqSavedState} = {1'b1, m};
    go();
    chk("return", {machineStateControl, waitState}, {m, 1'b1});
    debugClearWait = 1;
    go();
    chk("dclr", waitState, 1'b0);
    end_of_test();
  end
endmodule
bind ccs_core_state ccs_properties props (.*);
